// File: design/pkt_gate_pkg.sv
// Constants for the serial packet layer and checksum gate
// Assumes a host acting as serial master with 32-bit packets
package pkt_gate_pkg;
  // ************************************************
  // Packet framing
  // ************************************************
  localparam int PKT_BITS = 32;
  localparam int ID_MSB = 31;
  localparam int ID_LSB = 24;
  localparam int INFO_BITS = 24;
  localparam int CNT_W = 5;
  localparam logic [4:0] LAST_BIT = 5'h1f;
  // Identification value, arbitrary neutral choice
  localparam logic [23:0] IDENT_VALUE = 24'h000106;
  // ************************************************
  // Host-to-decoder identifiers
  // ************************************************
  localparam logic [7:0] ID_CHECKSUM = 8'h00;
  localparam logic [7:0] ID_CONFIG = 8'h01;
  localparam logic [7:0] ID_CONTROL = 8'h02;
  localparam logic [7:0] ID_ALLFRAME = 8'h03;
  localparam logic [7:0] ID_RSV0_LO = 8'h04;
  localparam logic [7:0] ID_RSV0_HI = 8'h0e;
  localparam logic [7:0] ID_RXLINE = 8'h0f;
  localparam logic [7:0] ID_RXCFG_LO = 8'h10;
  localparam logic [7:0] ID_RXCFG_HI = 8'h1b;
  localparam logic [7:0] ID_SPECIAL_LO = 8'h1c;
  localparam logic [7:0] ID_SPECIAL_HI = 8'h1f;
  localparam logic [7:0] ID_FRAME_LO = 8'h20;
  localparam logic [7:0] ID_FRAME_HI = 8'h27;
  localparam logic [7:0] ID_UADDR_EN = 8'h78;
  localparam logic [7:0] ID_UADDR_LO = 8'h80;
  localparam logic [7:0] ID_UADDR_HI = 8'h8f;
  localparam logic [6:0] FRAME_TOP = 7'h70;
  // ************************************************
  // Decoder-to-host identifiers
  // ************************************************
  localparam logic [7:0] OUT_BLOCK = 8'h00;
  localparam logic [7:0] OUT_ADDR = 8'h01;
  localparam logic [7:0] OUT_WORD_LO = 8'h02;
  localparam logic [7:0] OUT_WORD_HI = 8'h57;
  localparam logic [7:0] OUT_STATUS = 8'h7f;
  localparam logic [7:0] OUT_IDENT = 8'hff;
  // ************************************************
  // Packet classes
  // ************************************************
  typedef enum logic [3:0] {
    CLS_CHECKSUM = 4'h0,
    CLS_CONFIG = 4'h1,
    CLS_CONTROL = 4'h2,
    CLS_ALLFRAME = 4'h3,
    CLS_RXLINE = 4'h4,
    CLS_RXCFG = 4'h5,
    CLS_SPECIAL = 4'h6,
    CLS_FRAME = 4'h7,
    CLS_UADDR_EN = 4'h8,
    CLS_UADDR = 4'h9,
    CLS_RESERVED = 4'ha
  } class_type;
  // ************************************************
  // Transmit buffer
  // ************************************************
  localparam int TXB_DEPTH = 32;
  localparam int TXB_AW = 5;
  localparam logic [5:0] TXB_FULL = 6'h20;
endpackage : pkt_gate_pkg

// File: design/pkt_link_shift.sv
// Serial link shifter running on the host's serial clock
// Assumes select and data pins are stable around rising serial edges
`timescale 1ns/100ps
module pkt_link_shift (
  // Link clock and select
  input wire logic sck_in,
  input wire logic ss_n_in,
  // System reset, clears the event toggle
  input wire logic rst_n_in,
  // Serial data
  input wire logic mosi_in,
  output logic miso_out,
  // Word to send, held stable by core during a frame
  input wire logic [31:0] tx_word_in,
  // Received word and toggle event
  output logic [31:0] rx_word_out,
  output logic rx_tgl_out
);
  logic [4:0] cnt_ff;
  logic [31:0] sh_ff;
  logic [30:0] txs_ff;
  logic [31:0] nxt_sh;
  logic last_bit;
  assign nxt_sh = {sh_ff[30:0], mosi_in};
  assign last_bit = (cnt_ff == pkt_gate_pkg::LAST_BIT);
  assign miso_out = (cnt_ff == 5'h00) ? tx_word_in[31] : txs_ff[30];
  // ************************************************
  // Shift on rising edge, count reset by select
  // ************************************************
  // sample on rise
  always_ff @(posedge sck_in or posedge ss_n_in) begin
    if (ss_n_in) begin
      cnt_ff <= 5'h00;
    end else begin
      cnt_ff <= cnt_ff + 5'h01;
    end
  end
  always_ff @(posedge sck_in) begin
    sh_ff <= nxt_sh;
    if (cnt_ff == 5'h00) begin
      txs_ff <= tx_word_in[30:0];
    end else begin
      txs_ff <= {txs_ff[29:0], 1'b0};
    end
  end
  always_ff @(posedge sck_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_word_out <= 32'h00000000;
      rx_tgl_out <= 1'b0;
    end else if (last_bit) begin
      rx_word_out <= nxt_sh;
      rx_tgl_out <= ~rx_tgl_out;
    end
  end
endmodule : pkt_link_shift

// File: design/pkt_txbuf.sv
// Transmit packet buffer, 32 words
// Assumes one push and one pop per cycle at most
`timescale 1ns/100ps
module pkt_txbuf (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Fill side
  input wire logic push_in,
  input wire logic [31:0] data_in,
  // Drain side
  input wire logic pop_in,
  output logic [31:0] head_out,
  output logic empty_out,
  // Overflow clears pointers and count
  output logic overflow_out
);
  logic [31:0] mem [0:pkt_gate_pkg::TXB_DEPTH-1];
  logic [4:0] wr_ff;
  logic [4:0] rd_ff;
  logic [5:0] cnt_ff;
  logic full;
  logic do_push;
  logic do_pop;
  assign full = (cnt_ff == pkt_gate_pkg::TXB_FULL);
  assign empty_out = (cnt_ff == 6'h00);
  assign do_pop = pop_in && !empty_out;
  assign do_push = push_in && (!full || do_pop);
  assign head_out = mem[rd_ff];
  always_ff @(posedge clk_in) begin
    if (do_push) begin
      mem[wr_ff] <= data_in;
    end
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ff <= 5'h00;
      rd_ff <= 5'h00;
      cnt_ff <= 6'h00;
      overflow_out <= 1'b0;
    end else if (push_in && full && !do_pop) begin
      wr_ff <= 5'h00;
      rd_ff <= 5'h00;
      cnt_ff <= 6'h00;
      overflow_out <= 1'b1;
    end else begin
      overflow_out <= 1'b0;
      wr_ff <= wr_ff + {4'h0, do_push};
      rd_ff <= rd_ff + {4'h0, do_pop};
      cnt_ff <= cnt_ff + {5'h00, do_push} - {5'h00, do_pop};
    end
  end
endmodule : pkt_txbuf

// File: design/pkt_checksum_gate.sv
// Packet layer and checksum gate of a pager decoder serial slave
// Assumes the host is serial master and the decode core feeds packets
// Summary of operation
// - Packets are 32 bits: identifier byte on top, 24 info bits
// - Packet bit 31 goes first on the wire, bit 0 last
// - Identifiers 10 to 1B pick receiver settings in fixed order
// - Identifiers 1C to 1F are special, their only action is disabling output
// - Identifiers 20 to 27 assign frame groups, 112 downward
// - 78 enables user addresses, 80 to 8F assign addresses 0-15
// - Outgoing identifiers: 00 block, 01 address, words, 7F, FF
// - Only the control packet carries settings changed in use
// - Accumulator XORs info of all packets but checksum, special
// - Reset loads accumulator with the identification value
// - Output disabled at reset and on any non-checksum packet
// - While disabled, keep starting transfers with identification
// - Disabling output never stops decoding
// - Matching checksum packet enables output
// - Checksum packets ignored while output enabled
// - Enabled and buffer not empty: start transfer, send head
// - Status unbuffered, sent on host transfer while enabled with empty buffer
// - Both ends sample serial data on rising serial clock
// - Decoder start: ready low, host clocks 32, ready high
// - Host start: select, ready low, clock, ready high, deselect
// - 32-entry transmit buffer, overflow stops decode and clears
`timescale 1ns/100ps
module pkt_checksum_gate (
  // System clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Serial link
  input wire logic sck_in,
  input wire logic ss_n_in,
  input wire logic mosi_in,
  output logic miso_out,
  output logic miso_oe_out,
  output logic ready_n_out,
  // Decode core packet source
  input wire logic core_push_in,
  input wire logic [31:0] core_pkt_in,
  input wire logic [23:0] status_info_in,
  output logic decode_stop_out,
  // Received packet decode
  output logic rx_valid_out,
  output logic [7:0] rx_id_out,
  output logic [23:0] rx_info_out,
  output logic [3:0] rx_class_out,
  output logic [3:0] rx_index_out,
  output logic [6:0] rx_frame_base_out,
  output logic rx_fixed_cfg_out,
  output logic rx_runtime_cfg_out,
  // Gate state
  output logic out_enable_out,
  output logic [23:0] checksum_out
);
  // ************************************************
  // Functions
  // ************************************************
  function automatic logic in_range(input logic [7:0] v,
                                    input logic [7:0] lo,
                                    input logic [7:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction : in_range

  function automatic pkt_gate_pkg::class_type classify(input logic [7:0] v);
    if (v == pkt_gate_pkg::ID_CHECKSUM) begin
      classify = pkt_gate_pkg::CLS_CHECKSUM;
    end else if (v == pkt_gate_pkg::ID_CONFIG) begin
      classify = pkt_gate_pkg::CLS_CONFIG;
    end else if (v == pkt_gate_pkg::ID_CONTROL) begin
      classify = pkt_gate_pkg::CLS_CONTROL;
    end else if (v == pkt_gate_pkg::ID_ALLFRAME) begin
      classify = pkt_gate_pkg::CLS_ALLFRAME;
    end else if (v == pkt_gate_pkg::ID_RXLINE) begin
      classify = pkt_gate_pkg::CLS_RXLINE;
    end else if (in_range(v, pkt_gate_pkg::ID_RXCFG_LO,
                          pkt_gate_pkg::ID_RXCFG_HI)) begin
      classify = pkt_gate_pkg::CLS_RXCFG;
    end else if (in_range(v, pkt_gate_pkg::ID_SPECIAL_LO,
                          pkt_gate_pkg::ID_SPECIAL_HI)) begin
      classify = pkt_gate_pkg::CLS_SPECIAL;
    end else if (in_range(v, pkt_gate_pkg::ID_FRAME_LO,
                          pkt_gate_pkg::ID_FRAME_HI)) begin
      classify = pkt_gate_pkg::CLS_FRAME;
    end else if (v == pkt_gate_pkg::ID_UADDR_EN) begin
      classify = pkt_gate_pkg::CLS_UADDR_EN;
    end else if (in_range(v, pkt_gate_pkg::ID_UADDR_LO,
                          pkt_gate_pkg::ID_UADDR_HI)) begin
      classify = pkt_gate_pkg::CLS_UADDR;
    end else begin
      classify = pkt_gate_pkg::CLS_RESERVED;
    end
  endfunction : classify

  // ************************************************
  // Link side and crossing
  // ************************************************
  logic [31:0] rx_word_link;
  logic rx_tgl_link;
  logic [31:0] tx_word_ff;
  logic miso_link;
  logic [2:0] tgl_sync_ff;
  logic [1:0] ss_sync_ff;
  logic rx_evt;
  logic ss_n_s;

  pkt_link_shift u_link (
    .sck_in(sck_in),
    .ss_n_in(ss_n_in),
    .rst_n_in(rst_n_in),
    .mosi_in(mosi_in),
    .miso_out(miso_link),
    .tx_word_in(tx_word_ff),
    .rx_word_out(rx_word_link),
    .rx_tgl_out(rx_tgl_link)
  );

  assign miso_out = miso_link;
  assign miso_oe_out = !ss_n_in;
  assign rx_evt = tgl_sync_ff[2] ^ tgl_sync_ff[1];
  assign ss_n_s = ss_sync_ff[1];

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tgl_sync_ff <= 3'h0;
      ss_sync_ff <= 2'h3;
    end else begin
      tgl_sync_ff <= {tgl_sync_ff[1:0], rx_tgl_link};
      ss_sync_ff <= {ss_sync_ff[0], ss_n_in};
    end
  end

  // ************************************************
  // Received packet decode
  // ************************************************
  logic [7:0] rx_id;
  logic [23:0] rx_info;
  pkt_gate_pkg::class_type rx_cls;
  logic is_ck;
  logic ck_match;
  logic acc_skip;
  assign rx_id = rx_word_link[pkt_gate_pkg::ID_MSB:pkt_gate_pkg::ID_LSB];
  assign rx_info = rx_word_link[pkt_gate_pkg::INFO_BITS-1:0];
  assign rx_cls = classify(rx_id);
  assign is_ck = (rx_cls == pkt_gate_pkg::CLS_CHECKSUM);
  assign acc_skip = is_ck || (rx_cls == pkt_gate_pkg::CLS_SPECIAL);
  assign ck_match = (rx_info == checksum_out);

  logic [3:0] nxt_index;
  logic [6:0] nxt_frame;
  assign nxt_index = (rx_cls == pkt_gate_pkg::CLS_RXCFG) ?
                     rx_id[3:0] - pkt_gate_pkg::ID_RXCFG_LO[3:0] :
                     rx_id[3:0];
  assign nxt_frame = (rx_cls == pkt_gate_pkg::CLS_FRAME) ?
                     pkt_gate_pkg::FRAME_TOP - {rx_id[2:0], 4'h0} :
                     7'h00;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_valid_out <= 1'b0;
      rx_id_out <= 8'h00;
      rx_info_out <= 24'h000000;
      rx_class_out <= 4'h0;
      rx_index_out <= 4'h0;
      rx_frame_base_out <= 7'h00;
      rx_fixed_cfg_out <= 1'b0;
      rx_runtime_cfg_out <= 1'b0;
    end else begin
      rx_valid_out <= rx_evt && (rx_cls != pkt_gate_pkg::CLS_SPECIAL);
      if (rx_evt && (rx_cls != pkt_gate_pkg::CLS_SPECIAL)) begin
        rx_id_out <= rx_id;
        rx_info_out <= rx_info;
        rx_class_out <= rx_cls;
        rx_index_out <= nxt_index;
        rx_frame_base_out <= nxt_frame;
        rx_runtime_cfg_out <= (rx_cls == pkt_gate_pkg::CLS_CONTROL);
        rx_fixed_cfg_out <= (rx_cls == pkt_gate_pkg::CLS_CONFIG) ||
                            (rx_cls == pkt_gate_pkg::CLS_RXCFG) ||
                            (rx_cls == pkt_gate_pkg::CLS_FRAME) ||
                            (rx_cls == pkt_gate_pkg::CLS_UADDR_EN) ||
                            (rx_cls == pkt_gate_pkg::CLS_UADDR);
      end
    end
  end

  // ************************************************
  // Checksum accumulator and output gate
  // ************************************************
  // reset loads identification
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      checksum_out <= pkt_gate_pkg::IDENT_VALUE;
    end else if (rx_evt && !acc_skip) begin
      checksum_out <= checksum_out ^ rx_info;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      out_enable_out <= 1'b0;
    end else if (rx_evt && !is_ck) begin
      out_enable_out <= 1'b0;
    end else if (rx_evt && is_ck && !out_enable_out && ck_match) begin
      out_enable_out <= 1'b1;
    end
  end

  // ************************************************
  // Transmit selection and ready control
  // ************************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_XFER = 2'b10,
    ST_DONE = 2'b11
  } state_type;
  state_type state_ff;
  logic [31:0] buf_head;
  logic buf_empty;
  logic buf_pop;
  logic decode_ovf;
  logic dev_start;
  logic host_start;
  logic from_buf_ff;
  logic hold_ff;
  logic [31:0] nxt_word;

  pkt_txbuf u_buf (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .push_in(core_push_in),
    .data_in(core_pkt_in),
    .pop_in(buf_pop),
    .head_out(buf_head),
    .empty_out(buf_empty),
    .overflow_out(decode_ovf)
  );

  assign dev_start = !out_enable_out || !buf_empty;
  assign host_start = !ss_n_s;
  assign nxt_word = !out_enable_out ?
                    {pkt_gate_pkg::OUT_IDENT, pkt_gate_pkg::IDENT_VALUE} :
                    !buf_empty ? buf_head :
                    {pkt_gate_pkg::OUT_STATUS, status_info_in};
  assign buf_pop = (state_ff == ST_DONE) && from_buf_ff;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      decode_stop_out <= 1'b0;
    end else if (decode_ovf) begin
      decode_stop_out <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_ff <= ST_IDLE;
      ready_n_out <= 1'b1;
      tx_word_ff <= 32'h00000000;
      from_buf_ff <= 1'b0;
      hold_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          if (dev_start || host_start) begin
            tx_word_ff <= nxt_word;
            from_buf_ff <= out_enable_out && !buf_empty;
            state_ff <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          ready_n_out <= 1'b0;
          state_ff <= ST_XFER;
        end
        ST_XFER: begin
          if (rx_evt) begin
            ready_n_out <= 1'b1;
            state_ff <= ST_DONE;
          end
        end
        ST_DONE: begin
          // Two cycles, so a deselect has passed the synchroniser
          from_buf_ff <= 1'b0;
          hold_ff <= !hold_ff;
          if (hold_ff) begin
            state_ff <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ************************************************
  // Checks
  // ************************************************
  enable_on_match_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    rx_evt && is_ck && !out_enable_out && ck_match |=> out_enable_out)
    else $error("matching checksum did not enable output");
  disable_on_other_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    rx_evt && !is_ck |=> !out_enable_out)
    else $error("non-checksum packet did not disable output");
  acc_fold_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    rx_evt && !acc_skip |=>
    checksum_out == ($past(checksum_out) ^ $past(rx_info)))
    else $error("accumulator did not fold packet info");
  acc_hold_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    rx_evt && acc_skip |=> $stable(checksum_out))
    else $error("accumulator changed on skipped packet");
  ignore_ck_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    rx_evt && is_ck && out_enable_out |=> out_enable_out)
    else $error("checksum packet disabled output");
  ident_sent_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    state_ff == ST_IDLE && !out_enable_out |=>
    tx_word_ff[31:24] == pkt_gate_pkg::OUT_IDENT)
    else $error("identification not loaded while disabled");
  ready_start_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    state_ff == ST_IDLE && dev_start |=> ##1 !ready_n_out)
    else $error("ready not driven low for transfer");
  ready_end_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    state_ff == ST_XFER && rx_evt |=> ready_n_out)
    else $error("ready not released after packet");
endmodule : pkt_checksum_gate

// File: tb/spi_host_model.sv
// Host serial master model: drives select, serial clock and data
// Assumes the system clock is used only to poll the ready line and time the idle gap
`timescale 1ns/100ps
module spi_host_model (
  // Polling clock
  input wire logic clk_in,
  // Serial link
  output logic sck_out,
  output logic ss_n_out,
  output logic mosi_out,
  input wire logic miso_in,
  input wire logic ready_n_in
);
  initial begin
    sck_out = 1'b0;
    ss_n_out = 1'b1;
    mosi_out = 1'b0;
  end
  // ************************************************
  // Bounded wait for ready at a level
  // ************************************************
  task automatic wait_rdy(input logic lvl, output bit ok);
    int n;
    ok = 1'b0;
    for (n = 0; n < 400 && !ok; n++) begin
      @(negedge clk_in);
      ok = (ready_n_in === lvl);
    end
  endtask : wait_rdy
  // ************************************************
  // One full-duplex packet
  // ************************************************
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx,
                      output bit ok);
    int i;
    rx = 32'h0;
    ss_n_out = 1'b0;
    wait_rdy(1'b0, ok);
    if (ok) begin
      #53;
      for (i = 31; i >= 0; i--) begin
        mosi_out = tx[i];
        #62.5;
        rx = {rx[30:0], miso_in};
        sck_out = 1'b1;
        // hold select until ready high, pulse is short
        if (i == 0) begin
          wait_rdy(1'b1, ok);
        end else begin
          #62.5;
        end
        sck_out = 1'b0;
      end
    end
    ss_n_out = 1'b1;
    mosi_out = ~mosi_out;
    // Idle gap so the deselect is seen before the next packet
    repeat (2) @(negedge clk_in);
  endtask : xfer
endmodule : spi_host_model

// File: tb/spi_packet_checksum_gate_tb.sv
// Self-checking bench for the packet layer and checksum gate
// Assumes the host model in spi_host_model.sv
`timescale 1ns/100ps
module spi_packet_checksum_gate_tb;
  logic clk_in, rst_n_in, sck, ss_n, mosi, miso, miso_oe, ready_n;
  logic core_push, decode_stop, rx_valid, fixed_cfg, runtime_cfg;
  logic out_enable;
  logic [31:0] core_pkt, rx_w;
  logic [23:0] status_info, rx_info, cks, checksum;
  logic [7:0] rx_id;
  logic [3:0] rx_class, rx_index;
  logic [6:0] frame_base;
  int errors, tests_run, valid_cnt;
  pkt_checksum_gate dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .sck_in(sck), .ss_n_in(ss_n), .mosi_in(mosi), .miso_out(miso),
    .miso_oe_out(miso_oe), .ready_n_out(ready_n),
    .core_push_in(core_push), .core_pkt_in(core_pkt),
    .status_info_in(status_info), .decode_stop_out(decode_stop),
    .rx_valid_out(rx_valid), .rx_id_out(rx_id), .rx_info_out(rx_info),
    .rx_class_out(rx_class), .rx_index_out(rx_index),
    .rx_frame_base_out(frame_base), .rx_fixed_cfg_out(fixed_cfg),
    .rx_runtime_cfg_out(runtime_cfg), .out_enable_out(out_enable),
    .checksum_out(checksum));
  spi_host_model host_u (.clk_in(clk_in), .sck_out(sck),
    .ss_n_out(ss_n), .mosi_out(mosi), .miso_in(miso),
    .ready_n_in(ready_n));
  // Counts received-packet pulses, sampled where settled
  always @(negedge clk_in) begin
    if (rx_valid === 1'b1) valid_cnt++;
  end
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // ************************************************
  // Shared tasks
  // ************************************************
  task automatic end_sim();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic pkt(input logic [31:0] tx);
    bit ok;
    host_u.xfer(tx, rx_w, ok);
    chk(ok, 1'b1);
    if (!ok) end_sim();
    if (tx[31:24] != 8'h00 && tx[31:26] != 6'h07) cks = cks ^ tx[23:0];
  endtask : pkt
  // ************************************************
  // Scenarios
  // ************************************************
  task automatic t_start();
    bit ok;
    cks = pkt_gate_pkg::IDENT_VALUE;
    chk(checksum, cks);
    chk(miso_oe, 1'b0);
    chk(out_enable, 1'b0);
    host_u.wait_rdy(1'b0, ok);
    chk(ok, 1'b1);
    // reload after reset, legal identifiers only
    pkt(32'h01123456);
    chk(rx_w, {pkt_gate_pkg::OUT_IDENT, cks ^ 24'h123456});
    chk(rx_id, 8'h01);
    chk(rx_info, 24'h123456);
    chk(fixed_cfg, 1'b1);
    chk(checksum, cks);
    chk(valid_cnt, 32'h00000001);
    pkt(32'h1cabcdef);
    chk(checksum, cks);
    chk(rx_id, 8'h01);
    chk(valid_cnt, 32'h00000001);
  endtask : t_start
  task automatic t_classes();
    logic [7:0] ids [4] = '{8'h1b, 8'h21, 8'h8f, 8'h78};
    logic [3:0] cls [4] = '{4'h5, 4'h7, 4'h9, 4'h8};
    logic [6:0] aux [4] = '{7'h0b, 7'h60, 7'h0f, 7'h00};
    int i;
    for (i = 0; i < 4; i++) begin
      pkt({ids[i], {3{ids[i]}}});
      chk(rx_class, cls[i]);
      if (i == 1) chk(frame_base, aux[i]);
      else if (i != 3) chk(rx_index, aux[i]);
      chk(checksum, cks);
    end
  endtask : t_classes
  task automatic t_gate();
    pkt({8'h00, cks ^ 24'h000001});
    chk(out_enable, 1'b0);
    chk(checksum, cks);
    pkt({8'h00, cks});
    chk(out_enable, 1'b1);
    // Idle host answers with a null checksum packet
    pkt(32'h00000000);
    chk(out_enable, 1'b1);
    chk(rx_w, {pkt_gate_pkg::OUT_STATUS, status_info});
  endtask : t_gate
  task automatic t_output();
    bit ok;
    @(negedge clk_in);
    core_pkt = 32'h0213579b;
    core_push = 1'b1;
    @(negedge clk_in);
    core_push = 1'b0;
    host_u.wait_rdy(1'b0, ok);
    chk(ok, 1'b1);
    pkt(32'h00000000);
    chk(rx_w, 32'h0213579b);
    pkt(32'h02000001);
    chk(runtime_cfg, 1'b1);
    chk(out_enable, 1'b0);
  endtask : t_output
  task automatic t_overflow();
    int i;
    chk(decode_stop, 1'b0);
    for (i = 0; i < 33; i++) begin
      @(negedge clk_in);
      core_push = 1'b1;
      core_pkt = {8'h01, 24'(i)};
    end
    @(negedge clk_in);
    core_push = 1'b0;
    repeat (2) @(negedge clk_in);
    chk(decode_stop, 1'b1);
  endtask : t_overflow
  initial begin
    errors = 0;
    tests_run = 0;
    rst_n_in = 1'b0;
    core_push = 1'b0;
    core_pkt = 32'h0;
    status_info = 24'h5a5a5a;
    cks = 24'h0;
    valid_cnt = 0;
    repeat (10) @(negedge clk_in);
    rst_n_in = 1'b1;
    t_start();
    t_classes();
    t_gate();
    t_output();
    t_overflow();
    end_sim();
  end
endmodule : spi_packet_checksum_gate_tb
